// File: hdl/prs_pkg.sv
// package: constants and types of the program run sequencer
`default_nettype none
package prs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_ADDR = 8'h0c;
  localparam logic [7:0] OFF_RES = 8'h10;
  localparam logic [7:0] OFF_LABEL = 8'h14;
  localparam logic [7:0] OFF_IO = 8'h18;
  localparam logic [7:0] OFF_LINK = 8'h1c;

  typedef enum logic [1:0] {
    MODE_SEP = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_LEGACY = 2'h2
  } prs_mode_type;

  // gray codes along the normal scan path up to end processing; the return from end to main1 changes all four bits
  typedef enum logic [3:0] {
    PH_IDLE = 4'h0,
    PH_INIT = 4'h1,
    PH_MAIN1 = 4'h3,
    PH_STEP1 = 4'h2,
    PH_MAIN2 = 4'h6,
    PH_STEP2 = 4'h7,
    PH_MAIN3 = 4'h5,
    PH_STEP3 = 4'h4,
    PH_END = 4'hc
  } prs_phase_type;

  typedef enum logic [1:0] {
    AREA_BASIC = 2'h0,
    AREA_IO = 2'h1,
    AREA_EXT = 2'h2,
    AREA_BAD = 2'h3
  } prs_area_type;

  typedef struct packed {
    logic [25:0] rsvd;
    logic link3;
    logic link2;
    logic exec3;
    logic exec2;
    prs_mode_type mode;
  } prs_ctrl_type;

  typedef struct packed {
    logic [14:0] rsvd;
    logic [5:0] cap_kw;
    logic link_cmp;
    logic newgen;
    prs_mode_type mode;
    prs_phase_type phase;
    logic [1:0] halt;
    logic run;
  } prs_stat_type;

  typedef struct packed {
    logic pfx_valid;
    logic [1:0] pfx;
    prs_area_type area;
    logic [15:0] offset;
  } prs_addr_type;

  typedef struct packed {
    logic [8:0] rsvd;
    logic [1:0] cur_prog;
    prs_addr_type req;
  } prs_addr_reg_type;

  typedef struct packed {
    logic err;
    logic [10:0] rsvd;
    logic [1:0] bank;
    prs_area_type area;
    logic [15:0] offset;
  } prs_res_type;

  typedef struct packed {
    logic valid;
    logic [18:0] rsvd;
    logic shared;
    logic [10:0] num;
  } prs_label_type;

  typedef struct packed {
    logic [7:0] id;
    logic [4:0] out_words;
    logic [4:0] in_words;
    logic [5:0] ctrl_pts;
    logic [7:0] sig_pts;
  } prs_io_type;

  typedef struct packed {
    logic [22:0] rsvd;
    logic link_cmp;
    logic assigned;
    logic [2:0] slot;
    logic [3:0] rack;
  } prs_link_type;

  localparam prs_ctrl_type CTRL_RST = '{rsvd: 26'h0, link3: 1'b1, link2: 1'b1,
    exec3: 1'b1, exec2: 1'b1, mode: MODE_SEP};
  localparam logic [1:0] PROG_FIRST = 2'h1;
  localparam logic [1:0] BANK_COMMON = 2'h0;
  localparam logic [10:0] PRIV_LABELS = 11'h080;
  localparam logic [10:0] SHARED_LABELS = 11'h400;
  localparam logic [5:0] LEGACY_PROG_KW = 6'h20;
  localparam int unsigned SHARED_BASIC_KW = 24;
  localparam int unsigned KW_WORDS = 1024;
  localparam logic [7:0] SIG_POINTS = 8'h40;
  localparam logic [5:0] CTRL_POINTS = 6'h20;
  localparam logic [4:0] IO_WORDS = 5'h10;
  localparam logic [3:0] LINK_RACK = 4'hf;
  localparam logic [2:0] LINK_SLOT = 3'h0;
endpackage : prs_pkg
`default_nettype wire

// File: hdl/prs_addr_resolve.sv
// address resolver: maps a data address onto a basic bank or the common area
`default_nettype none
module prs_addr_resolve (
  input wire logic pclk,
  input wire logic presetn,
  input wire prs_pkg::prs_mode_type mode,
  input wire logic [1:0] cur_prog,
  input wire prs_pkg::prs_addr_type req,
  output var prs_pkg::prs_res_type res_q
);
  localparam logic [15:0] SHARED_WORDS =
    16'(prs_pkg::SHARED_BASIC_KW * prs_pkg::KW_WORDS);

  logic [1:0] owner;
  logic is_basic;
  logic common_basic;
  logic over;
  logic bad;
  prs_pkg::prs_res_type res_d;

  assign owner = req.pfx_valid ? req.pfx : cur_prog; // RL14
  assign is_basic = req.area == prs_pkg::AREA_BASIC;
  assign common_basic = mode != prs_pkg::MODE_SEP; // RL13
  assign over = common_basic && is_basic && req.offset >= SHARED_WORDS; // RL13
  // legacy mode knows only the first program and has no extended area
  assign bad = owner == 2'h0 || req.area == prs_pkg::AREA_BAD || over
    || (mode == prs_pkg::MODE_LEGACY
    && (owner != prs_pkg::PROG_FIRST || req.area == prs_pkg::AREA_EXT)); // RL10
  // private banks only for basic data in separate mode, io and ext common
  assign res_d.bank = (is_basic && !common_basic) ? owner : prs_pkg::BANK_COMMON; // RL12
  assign res_d.err = bad;
  assign res_d.rsvd = '0;
  assign res_d.area = req.area;
  assign res_d.offset = req.offset;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end
endmodule : prs_addr_resolve
`default_nettype wire

// File: hdl/prs_sequencer.sv
// program run sequencer top: apb registers, scan order, run link, data mode
//Function
// RL1 - each scan runs program one, two, three, then end processing; skips absent
// RL2 - program one always runs; two and three run only when enabled
// RL3 - program one always tied to run; two and three tie selectable
// RL4 - stop of a run-tied program drops run and halts all programs at once
// RL5 - stop of an untied program two or three keeps run and others going
// RL6 - each program's step program runs right after its main program
// RL7 - initial program runs once after power-up or restart before scanning
// RL8 - 128 private labels per program and 1024 shared labels
// RL9 - any operating mode change discards stored programs and data; a switch made by legacy_load does not raise program_clear
// RL10 - legacy mode: first program only, 32 kw, no extended area, no new functions
// RL11 - a load from legacy programming equipment switches into legacy mode
// RL12 - separate mode: private basic area per program, io and ext shared
// RL13 - shared mode: one 24 kw basic area common to all programs
// RL14 - a program-number prefix resolves in that program's basic area
// RL15 - built-in io reports 64 signal, 32 control points, 16/16 words, id code
// RL16 - comm port is computer link at rack f slot 0, else field network
//
// Added by the designer: the APB slave port and the placing of the registers.
`default_nettype none
module prs_sequencer #(
  parameter int unsigned ADDR_W = 8,
  parameter logic [7:0] IO_ID_CODE = 8'h5a // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_done,
  input wire logic [2:0] prog_stop,
  input wire logic start_sw,
  input wire logic legacy_load,
  output logic run_out,
  output var prs_pkg::prs_phase_type phase,
  output logic program_clear,
  output logic newgen_en,
  output logic link_is_computer
);
  prs_pkg::prs_ctrl_type ctrl_q;
  prs_pkg::prs_ctrl_type ctrl_d;
  prs_pkg::prs_phase_type phase_q;
  prs_pkg::prs_phase_type phase_d;
  prs_pkg::prs_addr_reg_type addr_q;
  prs_pkg::prs_label_type label_q;
  prs_pkg::prs_link_type link_q;
  prs_pkg::prs_res_type res_q;
  prs_pkg::prs_stat_type stat;
  prs_pkg::prs_io_type io_word;
  logic [1:0] halt_q;
  logic [1:0] halt_d;
  logic run_q;
  logic run_d;
  logic clear_q;
  logic newgen_q;
  logic link_cmp_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata;
  logic pready_q;
  logic pslverr_q;
  logic sw_meta_q;
  logic sw_sync_q;
  logic sw_prev_q;

  // apb decode
  logic setup;
  logic wr;
  logic hit_ctrl;
  logic hit_cmd;
  logic hit_stat;
  logic hit_addr;
  logic hit_res;
  logic hit_label;
  logic hit_io;
  logic hit_link;
  logic mapped;
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_q && pwrite && !pslverr_q;
  assign hit_ctrl = paddr == ADDR_W'(prs_pkg::OFF_CTRL);
  assign hit_cmd = paddr == ADDR_W'(prs_pkg::OFF_CMD);
  assign hit_stat = paddr == ADDR_W'(prs_pkg::OFF_STAT);
  assign hit_addr = paddr == ADDR_W'(prs_pkg::OFF_ADDR);
  assign hit_res = paddr == ADDR_W'(prs_pkg::OFF_RES);
  assign hit_label = paddr == ADDR_W'(prs_pkg::OFF_LABEL);
  assign hit_io = paddr == ADDR_W'(prs_pkg::OFF_IO);
  assign hit_link = paddr == ADDR_W'(prs_pkg::OFF_LINK);
  assign mapped = hit_ctrl || hit_cmd || hit_stat || hit_addr || hit_res
    || hit_label || hit_io || hit_link;

  // scan control terms
  prs_pkg::prs_ctrl_type wctrl;
  logic legacy;
  logic en2;
  logic en3;
  logic stop2;
  logic stop3;
  logic linked_stop;
  logic mode_chg;
  logic restart;
  logic quiet;
  assign wctrl = prs_pkg::prs_ctrl_type'(pwdata);
  assign legacy = ctrl_q.mode == prs_pkg::MODE_LEGACY;
  assign en2 = ctrl_q.exec2 && !legacy && !halt_q[0]; // RL2 RL10
  assign en3 = ctrl_q.exec3 && !legacy && !halt_q[1]; // RL2 RL10
  assign stop2 = prog_stop[1] && en2;
  assign stop3 = prog_stop[2] && en3;
  // program one is tied to run without a choice
  assign linked_stop = phase_q != prs_pkg::PH_IDLE && (prog_stop[0]
    || (stop2 && ctrl_q.link2) || (stop3 && ctrl_q.link3)); // RL3 RL4
  assign mode_chg = wr && hit_ctrl && wctrl.mode != ctrl_q.mode
    && wctrl.mode != prs_pkg::AREA_BAD && !legacy_load; // RL9
  assign restart = (sw_sync_q && !sw_prev_q) || (wr && hit_cmd && pwdata[0]);
  assign quiet = !mode_chg && !linked_stop && !restart;

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      prs_pkg::PH_INIT: if (step_done) phase_d = prs_pkg::PH_MAIN1; // RL7
      prs_pkg::PH_MAIN1: if (step_done) phase_d = prs_pkg::PH_STEP1; // RL6
      prs_pkg::PH_STEP1: begin
        if (step_done) begin
          phase_d = en2 ? prs_pkg::PH_MAIN2 : en3 ? prs_pkg::PH_MAIN3 : prs_pkg::PH_END; // RL1
        end
      end
      // a program disabled while running (e.g. switch to legacy) is left at once
      prs_pkg::PH_MAIN2: begin
        if (stop2 || !en2) phase_d = en3 ? prs_pkg::PH_MAIN3 : prs_pkg::PH_END; // RL5 RL2
        else if (step_done) phase_d = prs_pkg::PH_STEP2; // RL6
      end
      prs_pkg::PH_STEP2: begin
        if (stop2 || !en2 || step_done) begin
          phase_d = en3 ? prs_pkg::PH_MAIN3 : prs_pkg::PH_END; // RL1
        end
      end
      prs_pkg::PH_MAIN3: begin
        if (stop3 || !en3) phase_d = prs_pkg::PH_END; // RL5 RL2
        else if (step_done) phase_d = prs_pkg::PH_STEP3; // RL6
      end
      prs_pkg::PH_STEP3: if (stop3 || !en3 || step_done) phase_d = prs_pkg::PH_END; // RL1
      prs_pkg::PH_END: if (step_done) phase_d = prs_pkg::PH_MAIN1; // RL1
      default: phase_d = prs_pkg::PH_IDLE;
    endcase
    if (mode_chg || linked_stop) phase_d = prs_pkg::PH_IDLE; // RL4 RL9
    else if (restart) phase_d = prs_pkg::PH_INIT; // RL7
  end

  always_comb begin
    halt_d = halt_q;
    run_d = run_q;
    if (stop2) halt_d[0] = 1'b1; // RL5
    if (stop3) halt_d[1] = 1'b1; // RL5
    if (phase_q == prs_pkg::PH_INIT && step_done) run_d = 1'b1;
    if (mode_chg || linked_stop) begin
      run_d = 1'b0; // RL4
      halt_d = 2'b11;
    end else if (restart) begin
      run_d = 1'b0;
      // a stop in the restart cycle still sets its halt
      halt_d = {stop3, stop2}; // RL5
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && hit_ctrl) begin
      ctrl_d = wctrl;
      ctrl_d.rsvd = '0;
      if (wctrl.mode == prs_pkg::AREA_BAD) ctrl_d.mode = ctrl_q.mode;
    end
    if (legacy_load) ctrl_d.mode = prs_pkg::MODE_LEGACY; // RL11
  end

  // status, io identity and read mux
  logic label_ok;
  assign label_ok = label_q.shared ? label_q.num < prs_pkg::SHARED_LABELS
    : label_q.num < prs_pkg::PRIV_LABELS; // RL8
  assign stat = '{rsvd: '0, cap_kw: legacy ? prs_pkg::LEGACY_PROG_KW : 6'h00,
    link_cmp: link_cmp_q, newgen: newgen_q, mode: ctrl_q.mode, phase: phase_q,
    halt: halt_q, run: run_q};
  assign io_word = '{id: IO_ID_CODE, out_words: prs_pkg::IO_WORDS,
    in_words: prs_pkg::IO_WORDS, ctrl_pts: prs_pkg::CTRL_POINTS,
    sig_pts: prs_pkg::SIG_POINTS}; // RL15

  always_comb begin
    rdata = 32'h0;
    if (hit_ctrl) rdata = ctrl_q;
    else if (hit_stat) rdata = stat;
    else if (hit_addr) rdata = addr_q;
    else if (hit_res) rdata = res_q;
    else if (hit_label) rdata = {label_ok, label_q[30:0]};
    else if (hit_io) rdata = io_word; // RL15
    else if (hit_link) rdata = {link_q[31:9], link_cmp_q, link_q[7:0]};
  end

  prs_addr_resolve u_resolve (
    .pclk(pclk),
    .presetn(presetn),
    .mode(ctrl_q.mode),
    .cur_prog(addr_q.cur_prog),
    .req(addr_q.req),
    .res_q(res_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_q <= 1'b0;
      sw_sync_q <= 1'b0;
      sw_prev_q <= 1'b0;
    end else begin
      sw_meta_q <= start_sw;
      sw_sync_q <= sw_meta_q;
      sw_prev_q <= sw_sync_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= prs_pkg::PH_INIT;
      run_q <= 1'b0;
      halt_q <= 2'b00;
      ctrl_q <= prs_pkg::CTRL_RST;
      clear_q <= 1'b0;
      newgen_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      run_q <= run_d;
      halt_q <= halt_d;
      ctrl_q <= ctrl_d;
      clear_q <= mode_chg; // RL9
      newgen_q <= ctrl_d.mode != prs_pkg::MODE_LEGACY; // RL10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
      label_q <= '0;
      link_q <= '0;
      link_cmp_q <= 1'b0;
    end else begin
      if (wr && hit_addr) addr_q <= {9'h0, pwdata[22:0]};
      if (wr && hit_label) label_q <= {20'h0, pwdata[11:0]};
      if (wr && hit_link) link_q <= {24'h0, pwdata[7:0]};
      link_cmp_q <= link_q.assigned && link_q.rack == prs_pkg::LINK_RACK
        && link_q.slot == prs_pkg::LINK_SLOT; // RL16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup) prdata_q <= rdata;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign run_out = run_q;
  assign phase = phase_q;
  assign program_clear = clear_q;
  assign newgen_en = newgen_q;
  assign link_is_computer = link_cmp_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_step1_done;
    phase_q == prs_pkg::PH_STEP1 && step_done && quiet;
  endsequence
  sequence s_clear_pulse;
    clear_q ##1 !clear_q;
  endsequence

  property p_order;
    s_step1_done ##0 en2 |=> phase_q == prs_pkg::PH_MAIN2;
  endproperty
  a_order: assert property (p_order) else $error("program two did not follow"); // RL1
  property p_exec_off;
    s_step1_done ##0 !en2 |=> phase_q != prs_pkg::PH_MAIN2;
  endproperty
  a_exec_off: assert property (p_exec_off) else $error("disabled program ran"); // RL2
  property p_first_tied;
    phase_q == prs_pkg::PH_MAIN1 && prog_stop[0] |=> !run_q ##0 phase_q == prs_pkg::PH_IDLE;
  endproperty
  a_first_tied: assert property (p_first_tied) else $error("program one stop kept run"); // RL3
  property p_linked_stop;
    linked_stop |=> !run_q && phase_q == prs_pkg::PH_IDLE && halt_q == 2'b11;
  endproperty
  a_linked_stop: assert property (p_linked_stop) else $error("linked stop missed"); // RL4
  property p_unlinked;
    run_q && stop2 && !ctrl_q.link2 && quiet |=> run_q && phase_q != prs_pkg::PH_IDLE;
  endproperty
  a_unlinked: assert property (p_unlinked) else $error("untied stop dropped run"); // RL5
  property p_step_after;
    phase_q == prs_pkg::PH_MAIN1 && step_done && quiet |=> phase_q == prs_pkg::PH_STEP1;
  endproperty
  a_step_after: assert property (p_step_after) else $error("step program skipped"); // RL6
  property p_init_once;
    phase_q == prs_pkg::PH_END && step_done && quiet |=> phase_q == prs_pkg::PH_MAIN1 ##1
      (phase_q != prs_pkg::PH_INIT || $past(restart));
  endproperty
  a_init_once: assert property (p_init_once) else $error("initial program rerun"); // RL7
  property p_mode_clear;
    mode_chg |=> s_clear_pulse;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode change kept programs"); // RL9
  property p_legacy;
    legacy && $past(legacy) |-> !newgen_q && phase_q != prs_pkg::PH_MAIN2
      && phase_q != prs_pkg::PH_MAIN3;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy mode ran new functions"); // RL10
  property p_auto_legacy;
    legacy_load |=> ctrl_q.mode == prs_pkg::MODE_LEGACY ##1 !newgen_q;
  endproperty
  a_auto_legacy: assert property (p_auto_legacy) else $error("no switch to legacy"); // RL11
  property p_link_port;
    link_q.assigned && link_q.rack == prs_pkg::LINK_RACK
      && link_q.slot == prs_pkg::LINK_SLOT |=> link_cmp_q;
  endproperty
  a_link_port: assert property (p_link_port) else $error("port not computer link"); // RL16
endmodule : prs_sequencer
`default_nettype wire

// File: dv/prs_engine_model.sv
// program engine model: reports each phase finished after a set delay
`default_nettype none
module prs_engine_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [3:0] dly,
  input wire prs_pkg::prs_phase_type phase,
  output logic step_done
);
  timeunit 1ns;
  timeprecision 1ps;
  prs_pkg::prs_phase_type last_q;
  logic [3:0] cnt_q;
  logic fired_q;
  // one report per phase entry; the idle phase is never reported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= prs_pkg::PH_IDLE;
      cnt_q <= 4'h0;
      fired_q <= 1'b0;
      step_done <= 1'b0;
    end else begin
      last_q <= phase;
      step_done <= 1'b0;
      if (phase != last_q) begin
        cnt_q <= 4'h0;
        fired_q <= 1'b0;
      end else if (go && !fired_q && phase != prs_pkg::PH_IDLE) begin
        if (cnt_q >= dly) begin
          step_done <= 1'b1;
          fired_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : prs_engine_model
`default_nettype wire

// File: dv/prs_sequencer_bench.sv
// testbench of the program run sequencer
`default_nettype none
module prs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] IO_ID = 8'h3c; // arbitrary value
  localparam prs_pkg::prs_phase_type IN = prs_pkg::PH_INIT;
  localparam prs_pkg::prs_phase_type M1 = prs_pkg::PH_MAIN1;
  localparam prs_pkg::prs_phase_type S1 = prs_pkg::PH_STEP1;
  localparam prs_pkg::prs_phase_type M2 = prs_pkg::PH_MAIN2;
  localparam prs_pkg::prs_phase_type S2 = prs_pkg::PH_STEP2;
  localparam prs_pkg::prs_phase_type M3 = prs_pkg::PH_MAIN3;
  localparam prs_pkg::prs_phase_type S3 = prs_pkg::PH_STEP3;
  localparam prs_pkg::prs_phase_type EN = prs_pkg::PH_END;
  logic pclk, presetn, psel, penable, pwrite, start_sw, legacy_load, go, errq;
  logic pready, pslverr, step_done, run_out, program_clear, newgen_en, link_is_computer;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic [2:0] prog_stop;
  logic [3:0] dly;
  prs_pkg::prs_phase_type phase;
  int fail_count, num_checks, clr_count;

  prs_sequencer #(.ADDR_W(8), .IO_ID_CODE(IO_ID)) prs_sequencer_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_done(step_done), .prog_stop(prog_stop), .start_sw(start_sw),
    .legacy_load(legacy_load), .run_out(run_out), .phase(phase),
    .program_clear(program_clear), .newgen_en(newgen_en),
    .link_is_computer(link_is_computer));
  prs_engine_model prs_engine_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
    .dly(dly), .phase(phase), .step_done(step_done));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (program_clear === 1'b1) clr_count++;

  task automatic print_verdict;
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk("pready", 32'h0, 32'h1);
  endtask : apb

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rdq & m, exp);
  endtask : rd

  // resolve an address and read the result once it has settled
  task automatic res(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b1, prs_pkg::OFF_ADDR, a);
    repeat (2) @(posedge pclk);
    rd("resolve", prs_pkg::OFF_RES, m, exp);
  endtask : res

  function automatic logic [31:0] aw(input logic [1:0] cur, input logic pv,
                                     input logic [1:0] pfx, input logic [1:0] ar,
                                     input logic [15:0] off);
    return {9'h0, cur, pv, pfx, ar, off};
  endfunction : aw

  task automatic wait_ph(input prs_pkg::prs_phase_type p);
    int n;
    n = 0;
    while (phase !== p && n < 300) begin
      @(negedge pclk);
      n++;
    end
    chk("phase reached", 32'(phase), 32'(p));
  endtask : wait_ph

  task automatic seq(input prs_pkg::prs_phase_type s[$]);
    prs_pkg::prs_phase_type cur;
    int n;
    wait_ph(s[0]);
    for (int i = 1; i < s.size(); i++) begin
      cur = phase;
      n = 0;
      while (phase === cur && n < 100) begin
        @(negedge pclk);
        n++;
      end
      chk("phase order", 32'(phase), 32'(s[i]));
    end
  endtask : seq

  task automatic stop(input int idx);
    @(posedge pclk);
    prog_stop <= 3'(1 << idx);
    @(posedge pclk);
    prog_stop <= 3'h0;
    @(negedge pclk);
  endtask : stop

  task automatic t_regs;
    logic [11:0] lab[4] = '{12'h07f, 12'h080, 12'hbff, 12'hc00};
    logic [7:0] lnk[4] = '{8'h8f, 8'h0f, 8'h9f, 8'h8e};
    chk("phase", 32'(phase), 32'(IN));
    chk("run_out", 32'(run_out), 32'h0);
    @(negedge pclk);
    chk("newgen_en", 32'(newgen_en), 32'h1);
    rd("ctrl", prs_pkg::OFF_CTRL, 32'hffffffff, 32'h3c);
    rd("io", prs_pkg::OFF_IO, 32'hffffffff, {IO_ID, 5'h10, 5'h10, 6'h20, 8'h40});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'(errq), 32'h1);
    chk("unmapped data", rdq, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, prs_pkg::OFF_LABEL, {20'h0, lab[i]});
      rd("label valid", prs_pkg::OFF_LABEL, 32'h80000000, {i % 2 == 0, 31'h0});
      apb(1'b1, prs_pkg::OFF_LINK, {24'h0, lnk[i]});
      repeat (2) @(negedge pclk);
      chk("link kind", 32'(link_is_computer), 32'(i == 0));
      rd("link cmp", prs_pkg::OFF_LINK, 32'h100, {23'h0, i == 0, 8'h0});
    end
  endtask : t_regs

  task automatic t_scan;
    go <= 1'b1;
    seq('{IN, M1, S1, M2, S2, M3, S3, EN, M1});
    chk("run_out", 32'(run_out), 32'h1);
    apb(1'b1, prs_pkg::OFF_CTRL, 32'h38);
    seq('{M1, S1, M3, S3, EN, M1});
    apb(1'b1, prs_pkg::OFF_CTRL, 32'h34);
    seq('{M1, S1, M2, S2, EN, M1});
    chk("no clear", 32'(clr_count), 32'h0);
  endtask : t_scan

  task automatic t_stops;
    dly <= 4'h6;
    apb(1'b1, prs_pkg::OFF_CTRL, 32'h2c);
    wait_ph(M2);
    stop(1);
    chk("phase", 32'(phase), 32'(M3));
    chk("run_out", 32'(run_out), 32'h1);
    seq('{M1, S1, M3});
    rd("halt", prs_pkg::OFF_STAT, 32'h7, 32'h3);
    start_sw <= 1'b1;
    wait_ph(IN);
    chk("run_out", 32'(run_out), 32'h0);
    @(posedge pclk);
    start_sw <= 1'b0;
    apb(1'b1, prs_pkg::OFF_CTRL, 32'h3c);
    wait_ph(M3);
    stop(2);
    chk("run_out", 32'(run_out), 32'h0);
    rd("halt", prs_pkg::OFF_STAT, 32'h7, 32'h6);
    apb(1'b1, prs_pkg::OFF_CMD, 32'h1);
    seq('{IN, M1});
    stop(0);
    chk("run_out", 32'(run_out), 32'h0);
    apb(1'b1, prs_pkg::OFF_CMD, 32'h1);
    wait_ph(IN);
  endtask : t_stops

  task automatic t_modes;
    res(aw(1, 1, 2, 0, 16'h0100), 32'h800fffff, {12'h0, 4'h8, 16'h0100});
    res(aw(3, 0, 0, 0, 16'h0200), 32'h800fffff, {12'h0, 4'hc, 16'h0200});
    res(aw(2, 0, 0, 1, 16'h0010), 32'h800fffff, {12'h0, 4'h1, 16'h0010});
    res(aw(2, 0, 0, 2, 16'h0010), 32'h800fffff, {12'h0, 4'h2, 16'h0010});
    apb(1'b1, prs_pkg::OFF_CTRL, 32'h3d);
    wait_ph(prs_pkg::PH_IDLE);
    chk("program_clear", 32'(program_clear), 32'h1);
    @(negedge pclk);
    chk("clear", 32'(clr_count), 32'h1);
    res(aw(2, 0, 0, 0, 16'h5fff), 32'h800c0000, 32'h0);
    res(aw(2, 0, 0, 0, 16'h6000), 32'h80000000, 32'h80000000);
    @(posedge pclk);
    legacy_load <= 1'b1;
    @(posedge pclk);
    legacy_load <= 1'b0;
    @(negedge pclk);
    chk("newgen_en", 32'(newgen_en), 32'h0);
    rd("legacy stat", prs_pkg::OFF_STAT, 32'h1fb80, 32'h10100);
    res(aw(2, 0, 0, 0, 16'h0000), 32'h80000000, 32'h80000000);
    res(aw(1, 0, 0, 2, 16'h0000), 32'h80000000, 32'h80000000);
    apb(1'b1, prs_pkg::OFF_CMD, 32'h1);
    seq('{IN, M1, S1, EN, M1});
  endtask : t_modes

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start_sw = 1'b0;
    legacy_load = 1'b0;
    prog_stop = 3'h0;
    go = 1'b0;
    dly = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_regs;
    t_scan;
    t_stops;
    t_modes;
    print_verdict;
  end

  initial begin
    #1000000;
    fail_count++;
    print_verdict;
  end
endmodule : prs_sequencer_bench
`default_nettype wire
